// File: core/cluster_reset_boot_config_pkg.sv
/*
 * Constants for the cluster reset and boot configuration block:
 * register offsets, field positions, reset values and cycle counts.
 * Assumes a 32-bit APB with byte addresses, one register per word.
 */
package cluster_reset_boot_config_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int CPU_MAX = 4;
    localparam int CNT_W   = 16;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] MODE_OFF   = 8'h04;
    localparam logic [7:0] PERF_OFF   = 8'h08;
    // per-processor groups, word index = processor number
    localparam logic [3:0] SCR_GRP    = 4'h1;
    localparam logic [3:0] AFF_GRP    = 4'h2;
    localparam logic [3:0] VEC_GRP    = 4'h3;

    // ****************************************************************
    // status register fields
    // ****************************************************************
    localparam int ST_FULL_LSB   = 0;
    localparam int ST_CORE_LSB   = 4;
    localparam int ST_DBG_LSB    = 8;
    localparam int ST_L2_BIT     = 12;
    localparam int ST_L1BUSY_LSB = 16;
    localparam int ST_L2BUSY_BIT = 20;
    localparam int ST_LOCK_LSB   = 24;

    // ****************************************************************
    // system control register fields
    // ****************************************************************
    localparam int SCR_EE_BIT = 0;
    localparam int SCR_V_BIT  = 1;
    localparam int SCR_TE_BIT = 2;

    // affinity register cluster field
    localparam int AFF_CLUSTER_LSB = 8;

    // ****************************************************************
    // vector bases and reset values
    // ****************************************************************
    localparam logic [31:0] VEC_LOW_BASE  = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH_BASE = 32'hFFFF_0000;
    localparam logic [3:0]  MODE_RST      = 4'h0;

    // ****************************************************************
    // invalidate durations in cycles
    // ****************************************************************
    localparam logic [CNT_W-1:0] L1_INVAL_CYCLES = 16'h0040;
    localparam logic [CNT_W-1:0] L2_INVAL_CYCLES = 16'h0100;

endpackage : cluster_reset_boot_config_pkg

// File: core/strap_sync.sv
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ns
module strap_sync #(
    parameter int WIDTH   = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage is read only by the second
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : strap_sync

// File: core/cluster_reset_boot_config.sv
/*
 * Reset domain control and reset-time boot configuration for a
 * cluster of up to four processors, with performance monitor
 * interrupt and event export, behind an APB register slave.
 * Assumes the reset/power controller drives all pins asynchronously
 * and that internal monitor signals share ref_clk_i.
 */
`timescale 1ns/1ns
module cluster_reset_boot_config #(
    parameter int NUM_CPUS = 4,
    parameter int EVENT_W  = 30
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    // apb slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // reset pins from the power controller
    input  wire logic [3:0]         core_full_por_n_i,
    input  wire logic [3:0]         core_only_reset_n_i,
    input  wire logic [3:0]         debug_domain_reset_n_i,
    input  wire logic               shared_cache_ctrl_reset_n_i,
    // strap pins
    input  wire logic [3:0]         first_level_inval_skip_i,
    input  wire logic               second_level_inval_skip_i,
    input  wire logic [3:0]         boot_endian_strap_i,
    input  wire logic [3:0]         high_vector_strap_i,
    input  wire logic [3:0]         exception_state_strap_i,
    input  wire logic [3:0]         cluster_number_in_i,
    input  wire logic [3:0]         secure_sysreg_write_lock_i,
    // internal monitor, same clock
    input  wire logic               perf_irq_req_i,
    input  wire logic [EVENT_W-1:0] perf_events_i,
    // domain resets to the processor logic
    output logic      [3:0]         full_domain_rst_n_o,
    output logic      [3:0]         core_domain_rst_n_o,
    output logic      [3:0]         debug_logic_rst_n_o,
    output logic                    shared_ctrl_rst_n_o,
    // cache invalidate in progress
    output logic      [3:0]         first_level_inval_busy_o,
    output logic                    second_level_inval_busy_o,
    // boot configuration
    output logic      [3:0]         exception_endian_bit_o,
    output logic      [3:0]         high_vectors_o,
    output logic      [3:0]         exception_isa_bit_o,
    output logic      [3:0]         symmetric_mode_out_o,
    // performance monitor export
    output logic                    perf_monitor_irq_n_o,
    output logic      [EVENT_W-1:0] perf_event_bus_o
);

    // ****************************************************************
    // configuration mask
    // ****************************************************************
    // bit n set when processor n is built in
    localparam logic [3:0] CPU_PRESENT = 4'((5'd1 << NUM_CPUS) - 5'd1);

    // vector base from the vector-location bit
    function automatic logic [31:0] vec_base(input logic hi);
        vec_base = hi ? cluster_reset_boot_config_pkg::VEC_HIGH_BASE
                      : cluster_reset_boot_config_pkg::VEC_LOW_BASE;
    endfunction : vec_base

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    logic [37:0] pins_raw;
    logic [37:0] pins_sync;

    assign pins_raw = {secure_sysreg_write_lock_i, cluster_number_in_i,
                       exception_state_strap_i, high_vector_strap_i,
                       boot_endian_strap_i, second_level_inval_skip_i,
                       first_level_inval_skip_i, shared_cache_ctrl_reset_n_i,
                       debug_domain_reset_n_i, core_only_reset_n_i,
                       core_full_por_n_i};

    // resets synchronise to the asserted (low) level
    strap_sync #(
        .WIDTH   (38),
        .RST_VAL (38'h0_0000_0000)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pins_raw),
        .sync_o    (pins_sync)
    );

    wire [3:0] full_s  = pins_sync[3:0];
    wire [3:0] core_s  = pins_sync[7:4];
    wire [3:0] dbg_s   = pins_sync[11:8];
    wire       l2_s    = pins_sync[12];
    wire [3:0] l1sk_s  = pins_sync[16:13];
    wire       l2sk_s  = pins_sync[17];
    wire [3:0] end_s   = pins_sync[21:18];
    wire [3:0] vhi_s   = pins_sync[25:22];
    wire [3:0] te_s    = pins_sync[29:26];
    wire [3:0] clus_s  = pins_sync[33:30];
    wire [3:0] lock_s  = pins_sync[37:34];

    // ****************************************************************
    // reset domain decode
    // ****************************************************************
    // full reset covers the core and debug domains; the shared reset is separate
    wire [3:0] full_n  = full_s & CPU_PRESENT;
    wire [3:0] core_n  = full_n & core_s;
    wire [3:0] dbg_n   = full_n & dbg_s;
    // processor counts as in reset while its core domain is held
    wire [3:0] in_rst  = ~core_n;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire [1:0] cpu_sel   = paddr_i[3:2];
    wire [3:0] grp       = paddr_i[7:4];
    wire       aligned   = (paddr_i[1:0] == 2'b00);
    wire       hit_stat  = (paddr_i == cluster_reset_boot_config_pkg::STATUS_OFF);
    wire       hit_mode  = (paddr_i == cluster_reset_boot_config_pkg::MODE_OFF);
    wire       hit_perf  = (paddr_i == cluster_reset_boot_config_pkg::PERF_OFF);
    wire       hit_scr   = aligned && (grp == cluster_reset_boot_config_pkg::SCR_GRP);
    wire       hit_aff   = aligned && (grp == cluster_reset_boot_config_pkg::AFF_GRP);
    wire       hit_vec   = aligned && (grp == cluster_reset_boot_config_pkg::VEC_GRP);
    wire       hit_any   = hit_stat | hit_mode | hit_perf | hit_scr | hit_aff | hit_vec;
    wire       wr_ok     = hit_mode | hit_scr;

    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;

    // write commits at the edge where pready is seen high
    wire       acc_done  = psel_i & penable_i & pready_reg;
    wire       wr_fire   = acc_done & pwrite_i;
    wire       answer    = psel_i & penable_i & ~pready_reg;

    // ****************************************************************
    // per-processor state
    // ****************************************************************
    localparam int CPU_MAX_IDX = cluster_reset_boot_config_pkg::CPU_MAX - 1;

    logic [3:0]       ee_reg;
    logic [3:0]       vhi_reg;
    logic [3:0]       te_reg;
    logic [3:0]       clus_reg [CPU_MAX_IDX:0];
    logic [3:0]       l1sk_reg;
    logic             l2sk_reg;
    logic [3:0]       mode_reg;
    logic [3:0]       in_rst_d_reg;
    logic             l2_rst_d_reg;
    logic [3:0]       l1_busy_reg;
    logic             l2_busy_reg;
    logic [15:0]      l1_cnt_reg [CPU_MAX_IDX:0];
    logic [15:0]      l2_cnt_reg;

    // locked processors refuse control register writes
    wire scr_wr = wr_fire & hit_scr & CPU_PRESENT[cpu_sel]
                & ~in_rst[cpu_sel] & ~lock_s[cpu_sel];
    wire [3:0] l1_rel = in_rst_d_reg & ~in_rst;
    wire       l2_rel = l2_rst_d_reg & l2_s;

    // ****************************************************************
    // read data mux
    // ****************************************************************
    wire [31:0] stat_word =
        (32'(full_n)   << cluster_reset_boot_config_pkg::ST_FULL_LSB)
      | (32'(core_n)   << cluster_reset_boot_config_pkg::ST_CORE_LSB)
      | (32'(dbg_n)    << cluster_reset_boot_config_pkg::ST_DBG_LSB)
      | (32'(l2_s)     << cluster_reset_boot_config_pkg::ST_L2_BIT)
      | (32'(l1_busy_reg) << cluster_reset_boot_config_pkg::ST_L1BUSY_LSB)
      | (32'(l2_busy_reg) << cluster_reset_boot_config_pkg::ST_L2BUSY_BIT)
      | (32'(lock_s)   << cluster_reset_boot_config_pkg::ST_LOCK_LSB);
    wire [31:0] scr_word =
        (32'(ee_reg[cpu_sel])  << cluster_reset_boot_config_pkg::SCR_EE_BIT)
      | (32'(vhi_reg[cpu_sel]) << cluster_reset_boot_config_pkg::SCR_V_BIT)
      | (32'(te_reg[cpu_sel])  << cluster_reset_boot_config_pkg::SCR_TE_BIT);
    wire [31:0] aff_word =
        (32'(clus_reg[cpu_sel]) << cluster_reset_boot_config_pkg::AFF_CLUSTER_LSB)
      | 32'(cpu_sel);
    wire [31:0] vec_word = vec_base(vhi_reg[cpu_sel]);
    wire [31:0] rd_word =
        hit_stat ? stat_word :
        hit_mode ? 32'(mode_reg) :
        hit_perf ? 32'(~perf_monitor_irq_n_o) :
        hit_scr  ? scr_word :
        hit_aff  ? aff_word :
        hit_vec  ? vec_word : 32'h0000_0000;

    // ****************************************************************
    // apb response, one wait state
    // ****************************************************************
    // registered answer keeps pready glitch free
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            pready_reg  <= answer;
            pslverr_reg <= answer & (~hit_any | (pwrite_i & ~wr_ok));
            prdata_reg  <= (answer & ~pwrite_i & hit_any) ? rd_word : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // strap capture and control register
    // ****************************************************************
    // straps track pins during reset and freeze at release
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            ee_reg   <= 4'h0;
            vhi_reg  <= 4'h0;
            te_reg   <= 4'h0;
            l1sk_reg <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < cluster_reset_boot_config_pkg::CPU_MAX; i++)
            begin
                if (in_rst[i])
                begin
                    ee_reg[i]   <= end_s[i] & CPU_PRESENT[i];
                    vhi_reg[i]  <= vhi_s[i] & CPU_PRESENT[i];
                    te_reg[i]   <= te_s[i] & CPU_PRESENT[i];
                    l1sk_reg[i] <= l1sk_s[i];
                end
                else if (scr_wr && (cpu_sel == 2'(i)))
                begin
                    ee_reg[i]  <= pwdata_i[cluster_reset_boot_config_pkg::SCR_EE_BIT];
                    vhi_reg[i] <= pwdata_i[cluster_reset_boot_config_pkg::SCR_V_BIT];
                    te_reg[i]  <= pwdata_i[cluster_reset_boot_config_pkg::SCR_TE_BIT];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        for (int i = 0; i < cluster_reset_boot_config_pkg::CPU_MAX; i++)
        begin
            if (!rst_n_i)
                clus_reg[i] <= 4'h0;
            else if (in_rst[i])
                clus_reg[i] <= clus_s;
        end
    end

    // ****************************************************************
    // mode register
    // ****************************************************************
    // software sets symmetric mode per processor
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            mode_reg <= cluster_reset_boot_config_pkg::MODE_RST;
        else if (wr_fire && hit_mode)
            mode_reg <= pwdata_i[3:0] & CPU_PRESENT;
    end

    // ****************************************************************
    // level-one invalidate sequencers
    // ****************************************************************
    // invalidate after release unless skipped
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            in_rst_d_reg <= 4'hF;
            l1_busy_reg  <= 4'h0;
            for (int i = 0; i < cluster_reset_boot_config_pkg::CPU_MAX; i++)
                l1_cnt_reg[i] <= 16'h0000;
        end
        else
        begin
            in_rst_d_reg <= in_rst;
            for (int i = 0; i < cluster_reset_boot_config_pkg::CPU_MAX; i++)
            begin
                if (in_rst[i])
                begin
                    l1_busy_reg[i] <= 1'b0;
                end
                else if (l1_rel[i] && !l1sk_reg[i])
                begin
                    l1_busy_reg[i] <= 1'b1;
                    l1_cnt_reg[i]  <= cluster_reset_boot_config_pkg::L1_INVAL_CYCLES
                                    - 16'h0001;
                end
                else if (l1_busy_reg[i])
                begin
                    l1_busy_reg[i] <= (l1_cnt_reg[i] != 16'h0000);
                    l1_cnt_reg[i]  <= l1_cnt_reg[i] - 16'h0001;
                end
            end
        end
    end

    // ****************************************************************
    // level-two invalidate sequencer
    // ****************************************************************
    // shared invalidate after release unless skipped
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            l2_rst_d_reg <= 1'b1;
            l2sk_reg     <= 1'b0;
            l2_busy_reg  <= 1'b0;
            l2_cnt_reg   <= 16'h0000;
        end
        else
        begin
            l2_rst_d_reg <= ~l2_s;
            if (!l2_s)
            begin
                l2sk_reg    <= l2sk_s;
                l2_busy_reg <= 1'b0;
            end
            else if (l2_rel && !l2sk_reg)
            begin
                l2_busy_reg <= 1'b1;
                l2_cnt_reg  <= cluster_reset_boot_config_pkg::L2_INVAL_CYCLES
                             - 16'h0001;
            end
            else if (l2_busy_reg)
            begin
                l2_busy_reg <= (l2_cnt_reg != 16'h0000);
                l2_cnt_reg  <= l2_cnt_reg - 16'h0001;
            end
        end
    end

    // ****************************************************************
    // output registers
    // ****************************************************************
    // every output leaves a flop; absent processors stay in reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            full_domain_rst_n_o       <= 4'h0;
            core_domain_rst_n_o       <= 4'h0;
            debug_logic_rst_n_o       <= 4'h0;
            shared_ctrl_rst_n_o       <= 1'b0;
            first_level_inval_busy_o  <= 4'h0;
            second_level_inval_busy_o <= 1'b0;
            exception_endian_bit_o    <= 4'h0;
            high_vectors_o            <= 4'h0;
            exception_isa_bit_o       <= 4'h0;
            symmetric_mode_out_o      <= 4'h0;
            perf_monitor_irq_n_o      <= 1'b1;
            perf_event_bus_o          <= '0;
        end
        else
        begin
            full_domain_rst_n_o       <= full_n;
            core_domain_rst_n_o       <= core_n;
            debug_logic_rst_n_o       <= dbg_n;
            shared_ctrl_rst_n_o       <= l2_s;
            first_level_inval_busy_o  <= l1_busy_reg;
            second_level_inval_busy_o <= l2_busy_reg;
            exception_endian_bit_o    <= ee_reg;
            high_vectors_o            <= vhi_reg;
            exception_isa_bit_o       <= te_reg;
            symmetric_mode_out_o      <= mode_reg & CPU_PRESENT;
            perf_monitor_irq_n_o      <= ~perf_irq_req_i;
            perf_event_bus_o          <= perf_events_i;
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

endmodule : cluster_reset_boot_config

// File: bench/cluster_reset_boot_config_assertions.sv
/* port assertions for cluster_reset_boot_config, bound after the module
   assumes the perf inputs stay low while rst_n_i is low */
`timescale 1ns/1ns
module reset_boot_checker #(parameter int EVENT_W = 30) (
    input wire logic ref_clk_i, rst_n_i, psel_i, penable_i, pready_o, perf_irq_req_i,
    input wire logic perf_monitor_irq_n_o, shared_cache_ctrl_reset_n_i, shared_ctrl_rst_n_o,
    input wire logic [31:0] prdata_o,
    input wire logic [3:0] core_full_por_n_i, full_domain_rst_n_o, core_domain_rst_n_o,
    input wire logic [3:0] debug_logic_rst_n_o, first_level_inval_busy_o,
    input wire logic [EVENT_W-1:0] perf_events_i, perf_event_bus_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // one wait state, then a single answer cycle
    sequence s_acc; psel_i && penable_i && !pready_o; endsequence
    sequence s_ans; pready_o ##1 !pready_o; endsequence
    property p_ready; s_acc |=> s_ans; endproperty
    a_ready: assert property (p_ready) else $error("pready timing");
    property p_rdata; !pready_o |-> prdata_o == 32'h0000_0000; endproperty
    a_rdata: assert property (p_rdata) else $error("prdata outside answer");
    property p_irq; perf_monitor_irq_n_o == !$past(perf_irq_req_i); endproperty
    a_irq: assert property (p_irq) else $error("irq pin");
    property p_evt; perf_event_bus_o == $past(perf_events_i); endproperty
    a_evt: assert property (p_evt) else $error("event bus");
    property p_full; (!core_full_por_n_i[0]) [*3] |=>
        (full_domain_rst_n_o[0] | core_domain_rst_n_o[0] | debug_logic_rst_n_o[0]) == 1'b0;
    endproperty
    a_full: assert property (p_full) else $error("full reset");
    property p_l2; (!shared_cache_ctrl_reset_n_i) [*3] |=> !shared_ctrl_rst_n_o; endproperty
    a_l2: assert property (p_l2) else $error("shared reset");
    // no domain may leave reset ahead of the full reset
    property p_dom; ((core_domain_rst_n_o | debug_logic_rst_n_o) & ~full_domain_rst_n_o) == 4'h0;
    endproperty
    a_dom: assert property (p_dom) else $error("domain reset");
    property p_bclr; (!core_domain_rst_n_o[0]) [*2] |=> !first_level_inval_busy_o[0]; endproperty
    a_bclr: assert property (p_bclr) else $error("busy in reset");
endmodule : reset_boot_checker
bind cluster_reset_boot_config reset_boot_checker #(.EVENT_W(EVENT_W)) u_chk (.*);

// File: bench/power_ctrl_model.sv
/* power controller model: drives full resets, shared reset and straps
   assumes go_i is a one-cycle pulse given while busy_o is low */
`timescale 1ns/1ns
module power_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [3:0]  mask_i,
    input  wire logic [15:0] cfg_i,
    input  wire logic [4:0]  skip_i,
    output logic      [3:0]  por_n_o = 4'h0,
    output logic             l2_n_o = 1'b0,
    output logic      [15:0] strap_o = 16'h0000,
    output logic      [4:0]  skip_o = 5'h00,
    output logic             busy_o
);
    logic [4:0] cnt_reg = 5'h00;
    logic       first_reg = 1'b1;
    assign busy_o = (cnt_reg != 5'h00);
    // pins low ten cycles; straps scrambled six cycles after release
    always @(posedge clk_i)
    begin
        if (go_i)
        begin
            cnt_reg <= 5'h01;
            por_n_o <= por_n_o & ~mask_i;
            l2_n_o <= l2_n_o & ~(&mask_i);
            strap_o <= cfg_i;
            // skip straps low in first reset
            skip_o <= first_reg ? 5'h00 : skip_i;
        end
        else if (busy_o)
            cnt_reg <= (cnt_reg == 5'h10) ? 5'h00 : cnt_reg + 5'h01;
        if (cnt_reg == 5'h0a)
        begin
            por_n_o <= 4'hf;
            l2_n_o <= 1'b1;
            first_reg <= 1'b0;
        end
        if (cnt_reg == 5'h10)
        begin
            strap_o <= ~strap_o;
            skip_o <= ~skip_o;
        end
    end
endmodule : power_ctrl_model

// File: bench/cluster_reset_boot_config_bench.sv
/* bench: random reset runs, register reads, lock, refusals, domain pins
   assumes power_ctrl_model owns the full reset and strap pins except the lock pins */
`timescale 1ns/1ns
module cluster_reset_boot_config_bench;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic perf_irq_req_i = 1'b0, go = 1'b0, mbusy, er, shared_cache_ctrl_reset_n_i, pslverr_o;
    logic pready_o, shared_ctrl_rst_n_o, second_level_inval_busy_o, perf_monitor_irq_n_o;
    logic second_level_inval_skip_i;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic [3:0] core_only_reset_n_i = 4'hf, debug_domain_reset_n_i = 4'hf, mask = 4'hf, w4;
    logic [3:0] secure_sysreg_write_lock_i = 4'h0, core_full_por_n_i, first_level_inval_skip_i;
    logic [3:0] boot_endian_strap_i, high_vector_strap_i, exception_state_strap_i;
    logic [3:0] cluster_number_in_i, full_domain_rst_n_o, core_domain_rst_n_o;
    logic [3:0] debug_logic_rst_n_o, first_level_inval_busy_o, exception_endian_bit_o;
    logic [3:0] high_vectors_o, exception_isa_bit_o, symmetric_mode_out_o;
    logic [15:0] cfg = 16'h0000;
    logic [4:0] skip = 5'h00;
    logic [2:0] w;
    logic [29:0] perf_events_i = 30'h0000_0000, perf_event_bus_o;
    logic [6:0] e [4];
    logic [7:0] bad [4] = '{8'h00, 8'h08, 8'h20, 8'hfc};
    int err_count = 0, num_checks = 0, seed = 59336, n1, n2, k;
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (rst_n_i) {perf_irq_req_i, perf_events_i} <= 31'($random(seed));
    cluster_reset_boot_config dut (.*);
    power_ctrl_model pwr (.clk_i(ref_clk_i), .go_i(go), .mask_i(mask), .cfg_i(cfg),
        .skip_i(skip), .por_n_o(core_full_por_n_i), .l2_n_o(shared_cache_ctrl_reset_n_i),
        .strap_o({cluster_number_in_i, exception_state_strap_i, high_vector_strap_i,
        boot_endian_strap_i}), .skip_o({second_level_inval_skip_i, first_level_inval_skip_i}),
        .busy_o(mbusy));
    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    // apb master: setup, access held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1 && ++k < 20);
        rd = prdata_o; er = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        if (k == 20) begin err_count++; report_and_stop(); end
    endtask : apb
    // one controller reset; counts busy cycles of cpu 0 and level two
    task rst_run(input logic [3:0] m, input logic [4:0] s);
        mask <= m; skip <= s; cfg <= 16'($random(seed)); go <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        for (int i = 0; i < 4; i++) if (m[i]) e[i] = {cfg[15:12], cfg[8+i], cfg[4+i], cfg[i]};
        n1 = 0; n2 = 0; k = 0;
        do
        begin
            @(posedge ref_clk_i);
            k++; n1 += first_level_inval_busy_o[0]; n2 += second_level_inval_busy_o;
        end
        while ((mbusy || first_level_inval_busy_o != 4'h0 || second_level_inval_busy_o) && k < 600);
        if (k == 600) begin err_count++; report_and_stop(); end
        chk(n1, (m[0] && !s[0]) ? 32'(cluster_reset_boot_config_pkg::L1_INVAL_CYCLES) : 0);
        chk(n2, (&m && !s[4]) ? 32'(cluster_reset_boot_config_pkg::L2_INVAL_CYCLES) : 0);
    endtask : rst_run
    task cfg_check();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, {cluster_reset_boot_config_pkg::SCR_GRP, 2'(i), 2'b00}, 0);
            chk(rd, {29'h0, e[i][2:0]});
            chk({exception_isa_bit_o[i], high_vectors_o[i], exception_endian_bit_o[i]}, e[i][2:0]);
            apb(1'b0, {cluster_reset_boot_config_pkg::AFF_GRP, 2'(i), 2'b00}, 0);
            chk(rd, {20'h0, e[i][6:3], 6'h0, 2'(i)});
            apb(1'b0, {cluster_reset_boot_config_pkg::VEC_GRP, 2'(i), 2'b00}, 0);
            chk(rd, e[i][1] ? 32'hffff_0000 : 32'h0000_0000);
        end
    endtask : cfg_check
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rst_run(4'hf, 5'h00);
        repeat (3) begin cfg_check(); rst_run(4'($random(seed)), 5'($random(seed))); end
        $display("reset runs done");
        secure_sysreg_write_lock_i <= 4'($random(seed));
        repeat (4) @(posedge ref_clk_i);
        for (int i = 0; i < 4; i++)
        begin
            w = 3'($random(seed));
            apb(1'b1, {cluster_reset_boot_config_pkg::SCR_GRP, 2'(i), 2'b00}, {29'h0, w});
            if (!secure_sysreg_write_lock_i[i]) e[i][2:0] = w;
        end
        cfg_check();
        w4 = 4'($random(seed));
        apb(1'b1, 8'h04, {28'h0, w4});
        apb(1'b0, 8'h04, 0);
        chk(rd, {28'h0, w4});
        chk(symmetric_mode_out_o, w4);
        foreach (bad[j]) begin apb(1'b1, bad[j], 32'hffff_ffff); chk(er, 1'b1); end
        $display("register tests done");
        core_only_reset_n_i <= 4'hd; debug_domain_reset_n_i <= 4'hb;
        repeat (4) @(posedge ref_clk_i);
        chk({full_domain_rst_n_o, core_domain_rst_n_o, debug_logic_rst_n_o}, 12'hfdb);
        report_and_stop();
    end
endmodule : cluster_reset_boot_config_bench
